// [design/tcc_channel_regs.sv]
`timescale 1ns/1ps
// Function
// - writing one to a request bit calibrates that input, analog and digital
// - finished analog calibration updates the input's ten-bit calibration value
// - request bit clears itself only after successful analog calibration
// - newly enabled input sets its request bit: wake, reset, active or standby enable
// - any request bit left set after calibration sets the failure flag
// - noise flag or calibration value at limit leaves the request bit set
// - host writing zero before calibration reaches an input skips it
// - request register resets to zero, bit n-1 serves input n
// - interrupt enable bit lets touch assert active-low alert; resets to all ones
// - interrupt enable gates both touch and configured release interrupts
// - repeat off: one interrupt on touch, one on release if configured
// - repeat on, short touch: interrupt on touch and configured release
// - repeat on, hold: interrupt on touch then every repeat interval
// - guard enable bits drive guard per input, reset clear, bit four reserved
// - any guard enable disables sensor input five
// - with repeat on, touch longer than minimum press time is press-and-hold, 35 ms steps
// - repeat interval 35 ms to 560 ms in 35 ms steps, default 175 ms
module tcc_channel_regs #(
	parameter longint STEP_CYCLES = tcc_pkg::STEP_CYCLES_L
) (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       wake_from_sleep,
	input  wire logic       state_active,
	input  wire logic       state_standby,
	input  wire logic [7:0] active_enable,
	input  wire logic [7:0] standby_enable,
	input  wire logic [7:0] touch_detect,
	input  wire logic [7:0] noise_flag,
	input  wire logic       cal_meas_valid,
	input  wire logic [9:0] cal_meas_value,
	input  wire logic [7:0] release_interrupt_config,
	input  wire logic [3:0] autorepeat_interval,
	input  wire logic [3:0] min_press_time,
	output logic      [7:0] input_irq_event,
	output logic            alert_n,
	output logic            analog_calibration_failure_flag,
	output logic      [2:0] cal_channel,
	output logic            cal_busy,
	output logic      [9:0] input_calibration_value [8],
	output logic      [7:0] guard_drive,
	output logic            sensor_input_five_disable
);
	// =====================================================
	// helpers
	function automatic logic [31:0] steps_to_cycles(input logic [3:0] code);
		steps_to_cycles = 32'((longint'(code) + 1) * STEP_CYCLES);
	endfunction

	// =====================================================
	// registers
	logic [7:0] input_cal_request_r, input_cal_request_nxt;
	logic [7:0] input_irq_enable_r, input_irq_enable_nxt;
	logic [7:0] input_autorepeat_enable_r, input_autorepeat_enable_nxt;
	logic [7:0] input_guard_enable_r, input_guard_enable_nxt;
	logic       fail_r, fail_nxt;
	logic       first_r, first_nxt;
	logic [7:0] act_en_q_r, sby_en_q_r;
	logic       act_q_r, sby_q_r;
	logic [7:0] newly_en;
	tcc_pkg::tcc_cstate_t cst_r, cst_nxt;
	logic [2:0] ch_r, ch_nxt;
	logic [4:0] ccnt_r, ccnt_nxt;
	logic       cal_fault_seen_r, cal_fault_seen_nxt;
	logic [9:0] calv_r [8];
	logic [9:0] calv_nxt [8];

	// newly enabled inputs
	always_comb begin
		newly_en = '0;
		if (state_active) begin
			newly_en = active_enable & ~(act_q_r ? act_en_q_r : 8'h00);
		end
		if (state_standby) begin
			newly_en = newly_en | (standby_enable & ~(sby_q_r ? sby_en_q_r : 8'h00));
		end
		if (wake_from_sleep) begin
			newly_en = newly_en | (state_standby ? standby_enable : active_enable);
		end
	end

	// =====================================================
	// register file and calibration sequencer
	always_comb begin
		input_cal_request_nxt       = input_cal_request_r;
		input_irq_enable_nxt        = input_irq_enable_r;
		input_autorepeat_enable_nxt = input_autorepeat_enable_r;
		input_guard_enable_nxt      = input_guard_enable_r;
		fail_nxt                    = fail_r;
		first_nxt                   = 1'b0;
		cst_nxt                     = cst_r;
		ch_nxt                      = ch_r;
		ccnt_nxt                    = ccnt_r;
		cal_fault_seen_nxt          = cal_fault_seen_r;
		calv_nxt                    = calv_r;
		if (reg_wr) begin
			case (reg_addr)
				tcc_pkg::ADDR_CAL_REQ: begin
					input_cal_request_nxt = reg_wdata;
					fail_nxt = 1'b0;
				end
				tcc_pkg::ADDR_IRQ_EN: begin
					input_irq_enable_nxt = reg_wdata;
				end
				tcc_pkg::ADDR_RPT_EN: begin
					input_autorepeat_enable_nxt = reg_wdata;
				end
				tcc_pkg::ADDR_GUARD_EN: begin
					input_guard_enable_nxt = reg_wdata & tcc_pkg::GUARD_WRITE_MASK;
				end
				default: begin
				end
			endcase
		end
		case (cst_r)
			tcc_pkg::TCC_CAL_SCAN: begin
				if (input_cal_request_r[ch_r]) begin
					cst_nxt  = tcc_pkg::TCC_CAL_RUN;
					ccnt_nxt = '0;
				end else if (ch_r == 3'h7) begin
					ch_nxt = 3'h0;
					if (cal_fault_seen_r) begin
						fail_nxt = 1'b1;
					end
					cal_fault_seen_nxt = 1'b0;
				end else begin
					ch_nxt = ch_r + 3'h1;
				end
			end
			tcc_pkg::TCC_CAL_RUN: begin
				if (!input_cal_request_r[ch_r]) begin
					cst_nxt = tcc_pkg::TCC_CAL_SCAN;
				end else if (cal_meas_valid && ccnt_r >= 5'(tcc_pkg::CAL_CYCLES)) begin
					cst_nxt = tcc_pkg::TCC_CAL_DONE;
					calv_nxt[ch_r] = cal_meas_value;
				end else if (ccnt_r < 5'(tcc_pkg::CAL_CYCLES)) begin
					ccnt_nxt = ccnt_r + 5'h01;
				end
			end
			tcc_pkg::TCC_CAL_DONE: begin
				cst_nxt = tcc_pkg::TCC_CAL_SCAN;
				if (noise_flag[ch_r] || calv_r[ch_r] == tcc_pkg::CAL_MAX
						|| calv_r[ch_r] == tcc_pkg::CAL_MIN) begin
					cal_fault_seen_nxt = 1'b1;
				end else if (!(reg_wr && reg_addr == tcc_pkg::ADDR_CAL_REQ)) begin
					input_cal_request_nxt[ch_r] = 1'b0;
				end
				ch_nxt = ch_r + 3'h1;
				if (ch_r == 3'h7 && (cal_fault_seen_nxt)) begin
					fail_nxt = 1'b1;
					cal_fault_seen_nxt = 1'b0;
				end
			end
			default: begin
				cst_nxt = tcc_pkg::TCC_CAL_SCAN;
			end
		endcase
		input_cal_request_nxt = input_cal_request_nxt | newly_en;
		if (first_r) begin
			input_cal_request_nxt = input_cal_request_nxt
				| (state_standby ? standby_enable : active_enable);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			input_cal_request_r       <= tcc_pkg::RST_CAL_REQ;
			input_irq_enable_r        <= tcc_pkg::RST_IRQ_EN;
			input_autorepeat_enable_r <= tcc_pkg::RST_RPT_EN;
			input_guard_enable_r      <= tcc_pkg::RST_GUARD_EN;
			fail_r                    <= 1'b0;
			first_r                   <= 1'b1;
			act_en_q_r                <= '0;
			sby_en_q_r                <= '0;
			act_q_r                   <= 1'b0;
			sby_q_r                   <= 1'b0;
			cst_r                     <= tcc_pkg::TCC_CAL_SCAN;
			ch_r                      <= '0;
			ccnt_r                    <= '0;
			cal_fault_seen_r          <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				calv_r[i] <= tcc_pkg::CAL_INIT;
			end
		end else begin
			input_cal_request_r       <= input_cal_request_nxt;
			input_irq_enable_r        <= input_irq_enable_nxt;
			input_autorepeat_enable_r <= input_autorepeat_enable_nxt;
			input_guard_enable_r      <= input_guard_enable_nxt;
			fail_r                    <= fail_nxt;
			first_r                   <= first_nxt;
			act_en_q_r                <= active_enable;
			sby_en_q_r                <= standby_enable;
			act_q_r                   <= state_active;
			sby_q_r                   <= state_standby;
			cst_r                     <= cst_nxt;
			ch_r                      <= ch_nxt;
			ccnt_r                    <= ccnt_nxt;
			cal_fault_seen_r          <= cal_fault_seen_nxt;
			calv_r                    <= calv_nxt;
		end
	end

	// =====================================================
	// per-input touch, hold and repeat
	tcc_pkg::tcc_tstate_t tst_r [8];
	tcc_pkg::tcc_tstate_t tst_nxt [8];
	logic [31:0] tcnt_r [8];
	logic [31:0] tcnt_nxt [8];
	logic [7:0]  ev_r, ev_nxt;
	logic [7:0]  touch_eff;

	always_comb begin
		touch_eff = touch_detect;
		if (sensor_input_five_disable) begin
			touch_eff[tcc_pkg::GUARD_PIN_BIT] = 1'b0;
		end
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			tst_nxt[i]  = tst_r[i];
			tcnt_nxt[i] = tcnt_r[i];
			ev_nxt[i]   = 1'b0;
			case (tst_r[i])
				tcc_pkg::TCC_IDLE: begin
					if (touch_eff[i]) begin
						tst_nxt[i]  = tcc_pkg::TCC_TOUCH;
						tcnt_nxt[i] = '0;
						ev_nxt[i]   = 1'b1;
					end
				end
				tcc_pkg::TCC_TOUCH: begin
					if (!touch_eff[i]) begin
						tst_nxt[i] = tcc_pkg::TCC_IDLE;
						ev_nxt[i]  = release_interrupt_config[i];
					end else if (input_autorepeat_enable_r[i]
							&& tcnt_r[i] >= steps_to_cycles(min_press_time)) begin
						tst_nxt[i]  = tcc_pkg::TCC_HOLD;
						tcnt_nxt[i] = '0;
					end else begin
						tcnt_nxt[i] = tcnt_r[i] + 32'h1;
					end
				end
				tcc_pkg::TCC_HOLD: begin
					if (!touch_eff[i]) begin
						tst_nxt[i] = tcc_pkg::TCC_IDLE;
					end else if (tcnt_r[i] + 32'h1 >= steps_to_cycles(autorepeat_interval)) begin
						tcnt_nxt[i] = '0;
						ev_nxt[i]   = input_autorepeat_enable_r[i];
					end else begin
						tcnt_nxt[i] = tcnt_r[i] + 32'h1;
					end
				end
				default: begin
					tst_nxt[i] = tcc_pkg::TCC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ev_r <= '0;
			for (int i = 0; i < 8; i++) begin
				tst_r[i]  <= tcc_pkg::TCC_IDLE;
				tcnt_r[i] <= '0;
			end
		end else begin
			ev_r   <= ev_nxt;
			tst_r  <= tst_nxt;
			tcnt_r <= tcnt_nxt;
		end
	end

	// =====================================================
	// outputs and read mux
	assign input_irq_event = ev_r & input_irq_enable_r;
	assign alert_n         = ~(|input_irq_event);
	assign analog_calibration_failure_flag = fail_r;
	assign cal_channel     = ch_r;
	assign cal_busy        = (cst_r != tcc_pkg::TCC_CAL_SCAN);
	assign input_calibration_value = calv_r;
	assign guard_drive     = input_guard_enable_r;
	assign sensor_input_five_disable = |input_guard_enable_r;

	always_comb begin
		case (reg_addr)
			tcc_pkg::ADDR_CAL_REQ:  reg_rdata = input_cal_request_r;
			tcc_pkg::ADDR_IRQ_EN:   reg_rdata = input_irq_enable_r;
			tcc_pkg::ADDR_RPT_EN:   reg_rdata = input_autorepeat_enable_r;
			tcc_pkg::ADDR_GUARD_EN: reg_rdata = input_guard_enable_r;
			default:                reg_rdata = 8'h00;
		endcase
	end
endmodule

// [design/tcc_pkg.sv]
package tcc_pkg;
	// =====================================================
	// register map
	localparam logic [7:0] ADDR_CAL_REQ     = 8'h26;
	localparam logic [7:0] ADDR_IRQ_EN      = 8'h27;
	localparam logic [7:0] ADDR_RPT_EN      = 8'h28;
	localparam logic [7:0] ADDR_GUARD_EN    = 8'h29;
	localparam logic [7:0] RST_CAL_REQ      = 8'h00;
	localparam logic [7:0] RST_IRQ_EN       = 8'hFF;
	localparam logic [7:0] RST_RPT_EN       = 8'hFF;
	localparam logic [7:0] RST_GUARD_EN     = 8'h00;
	localparam logic [7:0] GUARD_WRITE_MASK = 8'hEF;
	localparam int         GUARD_PIN_BIT    = 4;
	// =====================================================
	// calibration limits
	localparam logic [9:0] CAL_MAX          = 10'h3FF;
	localparam logic [9:0] CAL_MIN          = 10'h000;
	localparam logic [9:0] CAL_INIT         = 10'h200;
	// =====================================================
	// timing
	localparam int         CLK_MHZ          = 250;
	localparam int         STEP_MS          = 35;
	localparam longint     STEP_CYCLES_L    = longint'(STEP_MS) * 1000 * CLK_MHZ;
	localparam logic [3:0] AUTOREPEAT_INTERVAL_RST     = 4'h4;
	localparam logic [3:0] MIN_PRESS_RST    = 4'h7;
	localparam int         CAL_CYCLES       = 16;
	// =====================================================
	// per-input touch tracking states, gray along idle-touch-hold
	typedef enum logic [1:0] {
		TCC_IDLE  = 2'b00,
		TCC_TOUCH = 2'b01,
		TCC_HOLD  = 2'b11
	} tcc_tstate_t;
	typedef enum logic [1:0] {
		TCC_CAL_SCAN = 2'b00,
		TCC_CAL_RUN  = 2'b01,
		TCC_CAL_DONE = 2'b11
	} tcc_cstate_t;
endpackage

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
	logic       clk_sys, reset, reg_wr, state_active, cal_meas_valid, alert_n, flag, busy, five;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, act_en, touch, rel_cfg, noise, irq_ev, guard, dly;
	logic [9:0] cal_val, cal_res, cal_vals [8];
	logic [2:0] cal_ch;
	logic       wake;
	int         err_count, samples_checked, ev_cnt [8];
	logic [7:0] rv [5] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
	tcc_channel_regs #(.STEP_CYCLES(10)) i_dut (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.wake_from_sleep(wake), .state_active(state_active), .state_standby(1'b0),
		.active_enable(act_en), .standby_enable(8'h00), .touch_detect(touch), .noise_flag(noise),
		.cal_meas_valid(cal_meas_valid), .cal_meas_value(cal_val), .release_interrupt_config(rel_cfg),
		.autorepeat_interval(4'h0), .min_press_time(4'h1), .input_irq_event(irq_ev), .alert_n(alert_n),
		.analog_calibration_failure_flag(flag), .cal_channel(cal_ch), .cal_busy(busy),
		.input_calibration_value(cal_vals), .guard_drive(guard), .sensor_input_five_disable(five));
	tcc_engine_model i_eng (.clk_sys(clk_sys), .cal_busy(busy), .delay(dly), .result(cal_res),
		.cal_meas_valid(cal_meas_valid), .cal_meas_value(cal_val));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		for (int i = 0; i < 8; i++) ev_cnt[i] += (irq_ev[i] === 1'b1);
	end
	task automatic chk(string n, logic [9:0] e, logic [9:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		@(posedge clk_sys);
		#1;
		chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, reg_rdata});
	endtask
	task automatic tap(int b, int n);
		@(posedge clk_sys);
		ev_cnt[b] = 0;
		touch[b] <= 1'b1;
		repeat (n) @(posedge clk_sys);
		touch[b] <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask
	task automatic cal_pass();
		int t;
		t = 0;
		for (int k = 0; k < 2; k++) begin
			while (cal_ch !== 3'h7 && t < 3000) begin @(posedge clk_sys); t++; end
			while (cal_ch === 3'h7 && t < 3000) begin @(posedge clk_sys); t++; end
		end
		chk("calibration pass", 10'h000, (t >= 3000) ? 10'h001 : 10'h000);
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		summarize();
	end
	initial begin
		{reset, reg_wr, reg_addr, reg_wdata, state_active} = {1'b1, 17'h0, 1'b1};
		wake = 1'b0;
		{act_en, touch, noise, rel_cfg, dly, cal_res} = {32'h0000_00FF, 8'h03, 10'h155};
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) rd(8'h26 + 8'(i), rv[i]);
		chk("flag", 10'h000, {9'h0, flag});
		$display("test reset done");
		wr(8'h29, 8'hFF);
		rd(8'h29, 8'hEF);
		chk("five", 10'h001, {9'h0, five});
		tap(4, 5);
		chk("guarded events", 10'h000, 10'(ev_cnt[4]));
		wr(8'h29, 8'h00);
		#1;
		chk("five", 10'h000, {9'h0, five});
		$display("test guard done");
		tap(0, 5);
		chk("tap events", 10'h002, 10'(ev_cnt[0]));
		wr(8'h28, 8'h00);
		tap(0, 100);
		chk("norepeat events", 10'h002, 10'(ev_cnt[0]));
		wr(8'h28, 8'hFF);
		tap(1, 100);
		chk("hold repeats", 10'h001, {9'h0, ev_cnt[1] >= 4});
		wr(8'h27, 8'hFE);
		tap(0, 5);
		chk("masked events", 10'h000, 10'(ev_cnt[0]));
		tap(2, 5);
		chk("open events", 10'h002, 10'(ev_cnt[2]));
		$display("test interrupts done");
		wr(8'h26, 8'h01);
		cal_pass();
		rd(8'h26, 8'h00);
		chk("cal value", 10'h155, cal_vals[0]);
		{cal_res, dly} = {10'h3FF, 8'd40};
		wr(8'h26, 8'h02);
		cal_pass();
		chk("flag", 10'h001, {9'h0, flag});
		rd(8'h26, 8'h02);
		while (busy !== 1'b0) @(posedge clk_sys);
		while (!(busy === 1'b1 && cal_ch === 3'h1)) @(posedge clk_sys);
		repeat (10) @(posedge clk_sys);
		wr(8'h26, 8'h00);
		rd(8'h26, 8'h00);
		@(posedge clk_sys);
		act_en <= 8'h04;
		cal_pass();
		rd(8'h26, 8'h04);
		cal_res <= 10'h155;
		cal_pass();
		rd(8'h26, 8'h00);
		chk("cal value 2", 10'h155, cal_vals[2]);
		@(posedge clk_sys);
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		rd(8'h26, 8'h04);
		cal_pass();
		rd(8'h26, 8'h00);
		$display("test calibration done");
		summarize();
	end
endmodule

// [test/tcc_channel_regs_chk.sv]
`timescale 1ns/1ps
// =========================================
// port checker
module tcc_channel_regs_chk (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] input_irq_event,
	input wire logic       alert_n,
	input wire logic       analog_calibration_failure_flag,
	input wire logic [2:0] cal_channel,
	input wire logic       cal_busy,
	input wire logic [7:0] guard_drive,
	input wire logic       sensor_input_five_disable
);
	logic [7:0] ien_r;
	logic [7:0] ien_nxt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// =========================================
	// shadow of interrupt enables
	always_comb begin
		ien_nxt = ien_r;
		if (reset)
			ien_nxt = tcc_pkg::RST_IRQ_EN;
		else if (reg_wr && reg_addr == tcc_pkg::ADDR_IRQ_EN)
			ien_nxt = reg_wdata;
	end
	always_ff @(posedge clk_sys) begin
		ien_r <= ien_nxt;
	end
	sequence s_cal_start;
		$rose(cal_busy);
	endsequence
	sequence s_cal_hold;
		(cal_busy && $stable(cal_channel)) [*8];
	endsequence
	// =========================================
	// assertions
	alert_map_a: assert property (alert_n == ~|input_irq_event)
		else $error("alert does not follow events");
	irq_gated_a: assert property ((input_irq_event & ~(ien_r | $past(ien_r))) == 8'h00)
		else $error("event on disabled input");
	irq_read_a: assert property (reg_addr == tcc_pkg::ADDR_IRQ_EN |-> reg_rdata == ien_r)
		else $error("interrupt enable readback wrong");
	guard_write_a: assert property (reg_wr && reg_addr == tcc_pkg::ADDR_GUARD_EN
		|=> guard_drive == ($past(reg_wdata) & tcc_pkg::GUARD_WRITE_MASK))
		else $error("guard write wrong");
	guard_read_a: assert property (reg_addr == tcc_pkg::ADDR_GUARD_EN |-> reg_rdata == guard_drive)
		else $error("guard readback wrong");
	five_off_a: assert property (sensor_input_five_disable == |guard_drive)
		else $error("input five disable wrong");
	reset_state_a: assert property ($fell(reset) |-> alert_n && guard_drive == 8'h00
		&& !analog_calibration_failure_flag)
		else $error("reset state wrong");
	cal_steady_a: assert property (s_cal_start |=> s_cal_hold)
		else $error("calibration channel unstable");
endmodule
bind tcc_channel_regs tcc_channel_regs_chk i_chk (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alert_n(alert_n),
	.input_irq_event(input_irq_event), .cal_channel(cal_channel), .cal_busy(cal_busy),
	.analog_calibration_failure_flag(analog_calibration_failure_flag), .guard_drive(guard_drive),
	.sensor_input_five_disable(sensor_input_five_disable));

// [test/tcc_engine_model.sv]
`timescale 1ns/1ps
// =========================================
// sensing engine stand-in, answers calibration runs
module tcc_engine_model (
	input  wire logic       clk_sys,
	input  wire logic       cal_busy,
	input  wire logic [7:0] delay,
	input  wire logic [9:0] result,
	output logic            cal_meas_valid,
	output logic      [9:0] cal_meas_value
);
	logic [7:0] cnt_r;
	initial begin
		cnt_r = 8'h00;
		cal_meas_valid = 1'b0;
		cal_meas_value = 10'h000;
	end
	// result after a settable delay, toggling junk otherwise
	always @(posedge clk_sys) begin
		cnt_r          <= cal_busy ? cnt_r + 8'h01 : 8'h00;
		cal_meas_valid <= cal_busy && cnt_r >= delay;
		cal_meas_value <= (cal_busy && cnt_r >= delay) ? result : ~cal_meas_value;
	end
endmodule
